// ==== bench/test_two_wire_register_slave.sv ====
// bench: master and slave joined on one link, user sides driven
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("FAIL %0t got %h want %h", $time, got, exp); end end
module test_two_wire_register_slave;
  logic       i_clk, i_reset_n, pin, req, st, sp, rd, nk;
  logic [7:0] dat, wr_addr, wr_data, rdat;
  logic       ready, done, acked, wr_stb, busy;
  int         bad_count, n_compared, n_stb, cyc, n0;
  twrs_if bus_if();
  twrs_slave twrs_slave_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr_select_pin(pin),
    .bus(bus_if.slave), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_wr_stb(wr_stb),
    .o_busy(busy));
  twrs_master twrs_master_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus_if.master),
    .i_req(req), .i_start(st), .i_stop(sp), .i_read(rd), .i_nack(nk), .i_data(dat),
    .o_ready(ready), .o_done(done), .o_data(rdat), .o_acked(acked));
  twrs_monitor twrs_monitor_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .scl_o_m(bus_if.scl_o_m), .scl_oe_n_m(bus_if.scl_oe_n_m), .sda_o_m(bus_if.sda_o_m),
    .sda_oe_n_m(bus_if.sda_oe_n_m), .sda_o_s(bus_if.sda_o_s),
    .sda_oe_n_s(bus_if.sda_oe_n_s), .scl(bus_if.scl), .sda(bus_if.sda));

  // clock, 25 ns period
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // write strobes counted and cycle ceiling; a hang becomes a failure
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) n_stb <= n_stb + 1;
    if (cyc == 90000) begin
      bad_count++;
      $display("FAIL %0t cycle limit reached", $time);
      print_verdict();
    end
  end

  function automatic logic [7:0] abyte(input logic sel, input logic rw);
    return {twrs_pkg::ADDR_UPPER, sel, rw};
  endfunction

  // one byte through the master; ready and done read at the falling edge
  task automatic xfer(input logic s, p, r, n, input logic [7:0] d);
    int w;
    w = 0;
    @(negedge i_clk);
    while (ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    req <= 1'b1;
    st <= s;
    sp <= p;
    rd <= r;
    nk <= n;
    dat <= d;
    @(posedge i_clk);
    req <= 1'b0;
    while (done !== 1'b1 && w < 5000) begin
      @(negedge i_clk);
      w++;
    end
    if (w >= 5000) begin
      bad_count++;
      $display("FAIL %0t no done", $time);
    end
  endtask

  task automatic t_mismatch();
    xfer(1, 0, 0, 0, abyte(1'b1, 1'b0));
    `CHK(acked, 1'b0)
    xfer(0, 1, 0, 0, 8'h00);
    `CHK(acked, 1'b0)
    `CHK(n_stb, 0)
    $display("test mismatch done");
  endtask

  task automatic t_write();
    n0 = n_stb;
    xfer(1, 0, 0, 0, abyte(1'b0, 1'b0));
    `CHK(acked, 1'b1)
    xfer(0, 0, 0, 0, 8'h05);
    `CHK(acked, 1'b1)
    xfer(0, 1, 0, 0, 8'hA6);
    `CHK(wr_addr, 8'h05)
    `CHK(wr_data, 8'hA6)
    `CHK(n_stb, n0 + 1)
    $display("test write done");
  endtask

  task automatic t_top();
    n0 = n_stb;
    xfer(1, 0, 0, 0, abyte(1'b0, 1'b0));
    xfer(0, 0, 0, 0, 8'h18);
    xfer(0, 0, 0, 0, 8'h11);
    `CHK(wr_addr, 8'h18)
    xfer(0, 0, 0, 0, 8'h22);
    `CHK(wr_addr, twrs_pkg::REG_TOP)
    xfer(0, 1, 0, 0, 8'h33);
    `CHK(wr_addr, twrs_pkg::REG_TOP)
    `CHK(n_stb, n0 + 3)
    $display("test top done");
  endtask

  task automatic t_read();
    xfer(1, 0, 0, 0, abyte(1'b0, 1'b0));
    xfer(0, 0, 0, 0, 8'h18);
    xfer(1, 0, 0, 0, abyte(1'b0, 1'b1));
    `CHK(acked, 1'b1)
    xfer(0, 0, 1, 0, 8'h00);
    `CHK(rdat, 8'h11)
    xfer(0, 1, 1, 1, 8'h00);
    `CHK(rdat, 8'h33)
    `CHK(bus_if.sda_oe_n_s, 1'b1)
    `CHK(busy, 1'b0)
    $display("test read done");
  endtask

  task automatic t_badbase();
    n0 = n_stb;
    xfer(1, 0, 0, 0, abyte(1'b0, 1'b0));
    xfer(0, 0, 0, 0, 8'h1A);
    `CHK(acked, 1'b0)
    xfer(0, 1, 0, 0, 8'h77);
    `CHK(acked, 1'b0)
    `CHK(n_stb, n0)
    $display("test badbase done");
  endtask

  task automatic t_pin();
    @(posedge i_clk);
    pin <= 1'b1;
    xfer(1, 0, 0, 0, abyte(1'b1, 1'b0));
    `CHK(acked, 1'b1)
    xfer(0, 0, 0, 0, 8'h00);
    xfer(0, 1, 0, 0, 8'h5A);
    `CHK(wr_addr, 8'h00)
    `CHK(wr_data, 8'h5A)
    $display("test pin done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    {i_reset_n, pin, req, st, sp, rd, nk} = '0;
    dat = 8'h00;
    {bad_count, n_compared, n_stb, cyc} = '0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_mismatch();
    t_write();
    t_top();
    t_read();
    t_badbase();
    t_pin();
    print_verdict();
  end
endmodule

// ==== bench/twrs_monitor.sv ====
// checker: wire-level relations on the shared two-wire link
`timescale 1ns/1ps
module twrs_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic scl_o_m,
  input wire logic scl_oe_n_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_n_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_n_s,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // open drain: an enabled driver may only pull low
  property p_slave_low;
    !sda_oe_n_s |-> !sda_o_s;
  endproperty
  a_slave_low: assert property (p_slave_low)
    else $error("slave drives sda high");
  property p_master_sda_low;
    !sda_oe_n_m |-> !sda_o_m;
  endproperty
  a_master_sda_low: assert property (p_master_sda_low)
    else $error("master drives sda high");
  property p_master_scl_low;
    !scl_oe_n_m |-> !scl_o_m;
  endproperty
  a_master_scl_low: assert property (p_master_scl_low)
    else $error("master drives scl high");

  // slave moves sda only in the low half of the clock
  property p_change_scl_low;
    $changed(sda_oe_n_s) |-> !scl;
  endproperty
  a_change_scl_low: assert property (p_change_scl_low)
    else $error("slave sda moved while scl high");

  // a start or stop drops any partial byte, so the slave stays off the wire
  property p_quiet_after_start;
    $fell(sda) && scl && $past(scl) |=> sda_oe_n_s [*8];
  endproperty
  a_quiet_after_start: assert property (p_quiet_after_start)
    else $error("slave drives right after start");
  property p_quiet_after_stop;
    $rose(sda) && scl && $past(scl) |=> sda_oe_n_s [*8];
  endproperty
  a_quiet_after_stop: assert property (p_quiet_after_stop)
    else $error("slave drives right after stop");

  // while the master holds sda low in a high clock, the slave lets go
  property p_one_driver;
    scl && !sda_oe_n_m |-> sda_oe_n_s;
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive sda");

  // clock high phase long enough for sampling
  property p_scl_high_hold;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high_hold: assert property (p_scl_high_hold)
    else $error("scl high phase too short");
endmodule

// ==== hw/twrs_if.sv ====
// interface: open-drain clock and data wires between master and slave
`timescale 1ns/1ps
interface twrs_if;
  logic scl_o_m;
  logic scl_oe_n_m;
  logic sda_o_m;
  logic sda_oe_n_m;
  logic sda_o_s;
  logic sda_oe_n_s;
  logic scl;
  logic sda;
  // wired-and with pull-ups; enables are active low
  assign scl = scl_oe_n_m ? 1'b1 : scl_o_m;
  assign sda = (sda_oe_n_m ? 1'b1 : sda_o_m) & (sda_oe_n_s ? 1'b1 : sda_o_s);
  modport slave  (input scl, input sda, output sda_o_s, output sda_oe_n_s);
  modport master (input scl, input sda, output scl_o_m, output scl_oe_n_m,
                  output sda_o_m, output sda_oe_n_m);
endinterface

// ==== hw/twrs_master.sv ====
// far end: two-wire master driving byte transfers on user request
`timescale 1ns/1ps
module twrs_master (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  twrs_if.master           bus,
  input  wire logic        i_req,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic        i_read,
  input  wire logic        i_nack,
  input  wire logic [7:0]  i_data,
  output logic             o_ready,
  output logic             o_done,
  output logic [7:0]       o_data,
  output logic             o_acked
);
  typedef enum logic [4:0] {
    M_IDLE  = 5'b00001,
    M_START = 5'b00010,
    M_BIT   = 5'b00100,
    M_STOP  = 5'b01000,
    M_HOLD  = 5'b10000
  } twrs_mstate_e;

  typedef struct packed {
    twrs_mstate_e state;
    logic [7:0]   cnt;
    logic [1:0]   phase;
    logic [3:0]   bit_idx;
    logic [7:0]   shift;
    logic         rd;
    logic         nack;
    logic         stop;
    logic         scl_low;
    logic         sda_low;
    logic [1:0]   sda_sync;
    logic         done;
    logic         acked;
    logic [7:0]   data;
  } twrs_master_s;

  twrs_master_s q;
  twrs_master_s d;
  logic tick;
  assign tick = (q.cnt == twrs_pkg::HALF_CNT);

  // quarter-bit sequencer; scl made here by dividing i_clk
  always_comb begin
    d          = q;
    d.sda_sync = {q.sda_sync[0], bus.sda};
    d.done     = 1'b0;
    d.cnt      = tick ? 8'h00 : 8'(q.cnt + 8'h01);
    unique case (q.state)
      M_IDLE, M_HOLD: begin
        d.cnt = 8'h00;
        if (i_req) begin
          d.shift = i_data;
          d.rd    = i_read;
          d.nack  = i_nack;
          d.stop  = i_stop;
          d.phase = 2'd0;
          d.bit_idx = twrs_pkg::BIT_FIRST;
          d.state = i_start ? M_START : M_BIT;
        end
      end
      M_START: if (tick) begin
        // release sda (scl low after a byte, still high from idle), raise scl, then pull sda low
        d.phase = 2'(q.phase + 2'd1);
        unique case (q.phase)
          2'd0: d.sda_low = 1'b0;
          2'd1: d.scl_low = 1'b0;
          2'd2: d.sda_low = 1'b1;
          2'd3: begin
            d.scl_low = 1'b1;
            d.state   = M_BIT;
          end
        endcase
      end
      M_BIT: if (tick) begin
        d.phase = 2'(q.phase + 2'd1);
        unique case (q.phase)
          2'd0: d.sda_low = (q.bit_idx < twrs_pkg::BIT_ACK) ?
                            (~q.rd & ~q.shift[7]) : (q.rd & ~q.nack);
          2'd1: d.scl_low = 1'b0;
          2'd2: if (q.bit_idx < twrs_pkg::BIT_ACK) begin
            d.shift = {q.shift[6:0], q.sda_sync[1]};
          end else begin
            d.acked = ~q.sda_sync[1];
          end
          2'd3: begin
            d.scl_low = 1'b1;
            d.bit_idx = 4'(q.bit_idx + 4'h1);
            if (q.bit_idx == twrs_pkg::BIT_ACK) begin
              d.data  = q.shift;
              d.state = q.stop ? M_STOP : M_HOLD;
              d.done  = ~q.stop;
              d.sda_low = q.stop;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        // sda low under low scl, release scl, then release sda
        d.phase = 2'(q.phase + 2'd1);
        unique case (q.phase)
          2'd0: d.sda_low = 1'b1;
          2'd1: d.scl_low = 1'b0;
          2'd2: d.sda_low = 1'b0;
          2'd3: begin
            d.state = M_IDLE;
            d.done  = 1'b1;
          end
        endcase
      end
      default: d.state = M_IDLE;
    endcase
  end

  // one register for the whole master state; both lines released in reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q          <= '0;
      q.state    <= M_IDLE;
      q.sda_sync <= 2'b11;
    end else begin
      q <= d;
    end
  end

  // open drain: pull low or release, never drive high
  assign bus.scl_o_m    = 1'b0;
  assign bus.scl_oe_n_m = ~q.scl_low;
  assign bus.sda_o_m    = 1'b0;
  assign bus.sda_oe_n_m = ~q.sda_low;
  assign o_ready        = (q.state == M_IDLE) || (q.state == M_HOLD);
  assign o_done         = q.done;
  assign o_data         = q.data;
  assign o_acked        = q.acked;
endmodule

// ==== hw/twrs_pkg.sv ====
// package: constants shared by both ends of the two-wire register link
package twrs_pkg;
  localparam logic [5:0] ADDR_UPPER   = 6'h26;   // slave address bits 7..2 (100110)
  localparam logic [7:0] REG_TOP      = 8'h19;   // highest register address
  localparam int         REG_COUNT    = 26;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [3:0] BIT_ACK      = 4'h8;    // bit index of acknowledge slot
  localparam logic [3:0] BIT_FIRST    = 4'h0;
  localparam int         CLK_MHZ      = 40;
  localparam int         SCL_HALF_NS  = 2500;    // master quarter-bit step; scl half period is two of these
  localparam int         SCL_HALF_CYC = SCL_HALF_NS * CLK_MHZ / 1000;
  localparam logic [7:0] HALF_CNT     = 8'(SCL_HALF_CYC - 1);
endpackage

// ==== hw/twrs_slave.sv ====
// device end: two-wire slave giving a master access to 26 byte registers
//
// Function
// - first seven bits are compared slave address
// - address low bit follows select pin
// - eighth bit selects read or write
// - matching address acked on ninth pulse
// - mismatch: no ack, idle until start
// - sda changes only while scl low
// - master starts by sda fall, scl high
// - stop returns the slave to idle
// - every byte shifted msb first
// - first written byte is register address
// - address steps by one per byte
// - address stops incrementing at top
// - base address above top not acked
// - no ack leaves sda released
// - master reads via write then restart
// - reads start at stored base address
// - master nack ends read, sda released
// - repeated start restarts address decoding
`timescale 1ns/1ps
module twrs_slave (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_addr_select_pin,
  twrs_if.slave            bus,
  output logic [7:0]       o_wr_addr,
  output logic [7:0]       o_wr_data,
  output logic             o_wr_stb,
  output logic             o_busy
);
  // one-hot phases of a transfer as seen by the slave
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_REG  = 5'b00100,
    ST_WDAT = 5'b01000,
    ST_RDAT = 5'b10000
  } twrs_state_e;

  // every flop of the slave except the register bank, registered as one word
  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic [1:0]  pin_sync;
    logic        scl_prev;
    logic        sda_prev;
    twrs_state_e state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  reg_addr;
    logic        drive_low;
    logic        ack_ok;
    logic        master_nack;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_stb;
  } twrs_slave_s;

  // whole state in one word; the bank of 26 bytes sits beside it
  twrs_slave_s q;
  twrs_slave_s d;
  logic [7:0]  regs [twrs_pkg::REG_COUNT];

  // saturating increment shared by write and read paths
  function automatic logic [7:0] twrs_next(input logic [7:0] a);
    twrs_next = (a >= twrs_pkg::REG_TOP) ? twrs_pkg::REG_TOP : 8'(a + 8'h01);
  endfunction

  // line levels after the synchronisers
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  // edges from synchronised levels; start and stop need scl high on both samples
  assign scl      = q.scl_sync[1];
  assign sda      = q.sda_sync[1];
  assign scl_rise = scl & ~q.scl_prev;
  assign scl_fall = ~scl & q.scl_prev;
  assign start_c  = scl & q.scl_prev & q.sda_prev & ~sda;
  assign stop_c   = scl & q.scl_prev & ~q.sda_prev & sda;

  // next-state logic; bits sampled on scl rise, sda moved on scl fall
  always_comb begin
    d          = q;
    d.scl_sync = {q.scl_sync[0], bus.scl};
    d.sda_sync = {q.sda_sync[0], bus.sda};
    // the select pin is static in use but still comes from outside
    d.pin_sync = {q.pin_sync[0], i_addr_select_pin};
    d.scl_prev = scl;
    d.sda_prev = sda;
    d.wr_stb   = 1'b0;
    if (start_c) begin
      d.state     = ST_ADDR;
      // the master's own scl fall after start is no data bit: it wraps this to the first
      d.bit_cnt   = 4'(twrs_pkg::BIT_FIRST - 4'h1);
      d.drive_low = 1'b0;
    end else if (stop_c) begin
      d.state     = ST_IDLE;
      d.drive_low = 1'b0;
    end else if (q.state != ST_IDLE) begin
      // sample at the rise; the sender had at least a quarter bit to settle
      if (scl_rise) begin
        if (q.bit_cnt < twrs_pkg::BIT_ACK) begin
          d.shift = {q.shift[6:0], sda};
        end else if (q.state == ST_RDAT) begin
          d.master_nack = sda;
        end
      end
      // all moves of our own drive happen here, early in the low half
      if (scl_fall) begin
        d.bit_cnt = 4'(q.bit_cnt + 4'h1);
        if (q.bit_cnt == 4'(twrs_pkg::BIT_ACK - 4'h1)) begin
          // end of byte: decide the acknowledge
          d.drive_low = 1'b0;
          unique case (q.state)
            ST_ADDR: begin
              // lowest bit of the address byte is the direction flag
              d.ack_ok = (q.shift[7:1] == {twrs_pkg::ADDR_UPPER, q.pin_sync[1]});
              if (d.ack_ok && q.shift[0]) begin
                d.reg_addr = q.reg_addr;
              end
            end
            ST_REG: begin
              // a refused base leaves the stored address as it was
              d.ack_ok = (q.shift <= twrs_pkg::REG_TOP);
              if (d.ack_ok) begin
                d.reg_addr = q.shift;
              end
            end
            ST_WDAT: begin
              // at the top every further byte of the burst lands on 0x19 again
              d.ack_ok  = 1'b1;
              d.wr_stb  = 1'b1;
              d.wr_addr = q.reg_addr;
              d.wr_data = q.shift;
              d.reg_addr = twrs_next(q.reg_addr);
            end
            ST_RDAT: begin
              d.ack_ok = 1'b0;                               // release for master ack
            end
            default: d.ack_ok = 1'b0;
          endcase
          d.drive_low = d.ack_ok;
        end else if (q.bit_cnt == twrs_pkg::BIT_ACK) begin
          // ack slot over: pick the next phase
          d.bit_cnt   = twrs_pkg::BIT_FIRST;
          d.drive_low = 1'b0;
          unique case (q.state)
            // no ack given: stay off the bus until the next start
            ST_ADDR: d.state = !q.ack_ok ? ST_IDLE : (q.shift[0] ? ST_RDAT : ST_REG);
            ST_REG:  d.state = q.ack_ok ? ST_WDAT : ST_IDLE;
            ST_WDAT: d.state = ST_WDAT;
            ST_RDAT: d.state = q.master_nack ? ST_IDLE : ST_RDAT;
            default: d.state = ST_IDLE;
          endcase
          // a sent byte moves the address on, acked or not
          if (q.state == ST_RDAT) begin
            d.reg_addr = twrs_next(q.reg_addr);
          end
          // reg_addr never passes the top, so the bank index stays in range
          if (d.state == ST_RDAT) begin
            d.shift     = regs[d.reg_addr[4:0]];
            d.drive_low = ~regs[d.reg_addr[4:0]][7];
          end
        end else if (q.state == ST_RDAT) begin
          // the sampling shift on the rise has moved the next bit to the top
          d.drive_low = ~q.shift[7];
        end
      end
    end
  end

  // state registers; constants only under reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q          <= '0;
      q.scl_sync <= 2'b11;
      q.sda_sync <= 2'b11;
      q.pin_sync <= 2'h0;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.state    <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // register bank written from the link
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < twrs_pkg::REG_COUNT; i++) begin
        regs[i] <= twrs_pkg::REG_RESET;
      end
    end else if (q.wr_stb) begin
      regs[q.wr_addr[4:0]] <= q.wr_data;
    end
  end

  // open drain: only low or released
  assign bus.sda_o_s    = 1'b0;
  assign bus.sda_oe_n_s = ~q.drive_low;
  assign o_wr_addr      = q.wr_addr;
  assign o_wr_data      = q.wr_data;
  assign o_wr_stb       = q.wr_stb;
  assign o_busy         = (q.state != ST_IDLE);
endmodule
